/* mtil_params.svh */
// Constants for the terminal interrupt logic: offsets, bit positions, resets and timings.
`ifndef MTIL_PARAMS_SVH
`define MTIL_PARAMS_SVH

// APB byte offsets of the registers.
`define MTIL_OFF_MASK 12'h000
`define MTIL_OFF_STAT 12'h004
`define MTIL_OFF_CFG2 12'h008
`define MTIL_OFF_CFG3 12'h00c
`define MTIL_OFF_CFG4 12'h010
`define MTIL_OFF_CFG5 12'h014
`define MTIL_OFF_CTRL 12'h018
`define MTIL_OFF_TTAG 12'h01c
`define MTIL_OFF_TRIG 12'h020

// Interrupt bit positions.
`define MTIL_B_EOM 0
`define MTIL_B_STSET 1
`define MTIL_B_FMT 2
`define MTIL_B_EOF 3
`define MTIL_B_CWEOM 4
`define MTIL_B_CBROLL 5
`define MTIL_B_TTROLL 6
`define MTIL_B_APAR 7
`define MTIL_B_RETRY 8

// Configuration bit positions.
`define MTIL_C2_EMM 1
`define MTIL_C2_LEVEL 3
`define MTIL_C2_AUTOCLR 4
`define MTIL_C2_REPLACE 11
`define MTIL_C2_ENHIRQ 15
`define MTIL_C3_EMC 0
`define MTIL_C3_ENH 15
`define MTIL_C4_BMASK 11
`define MTIL_C4_WIDECW 12
`define MTIL_CTRL_IRQRST 2
`define MTIL_BC_BCR 4

// Reset values.
`define MTIL_RST_REG 16'h0000

// Response timeout choices in tenths of a microsecond, and cycles at 50 MHz.
`define MTIL_CLK_MHZ 50
`define MTIL_TO0_DUS 185
`define MTIL_TO1_DUS 225
`define MTIL_TO2_DUS 505
`define MTIL_TO3_DUS 1300
`define MTIL_TO_CYC(d) (((d) * `MTIL_CLK_MHZ) / 10)

`endif

/* mtil_pkg.sv */
// Types shared by the terminal interrupt logic.
package mtil_pkg;

    // Operating role of the terminal.
    typedef enum logic [1:0] {
        MTIL_BC,
        MTIL_RT,
        MTIL_WMON,
        MTIL_MMON
    } mtil_mode_t;

    // One-cycle events reported by the protocol engine.
    typedef struct packed {
        logic msg_end;
        logic msg_err;
        logic retried;
        logic loop_fail;
        logic rsp_start;
        logic rsp_seen;
        logic rt2rt_rx;
        logic sts_valid;
        logic cmd_valid;
        logic stop_abort;
        logic buf_bottom;
        logic is_tx;
        logic is_modecode;
    } mtil_evt_t;

    // Per-message qualifiers from control words and shared RAM.
    typedef struct packed {
        logic [15:0] bc_ctrl;
        logic sa_roll_en;
        logic sa_eom_en;
        logic mc_irq_en;
        logic [15:0] msg_count;
        logic [15:0] rx_word;
        logic [4:0] exp_addr;
    } mtil_qual_t;

endpackage : mtil_pkg

/* mtil_timeout.sv */
// Response timeout counter with four selectable limits.
`timescale 1ns/10ps
`include "mtil_params.svh"

module mtil_timeout (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Control.
    input wire logic start_i,
    input wire logic seen_i,
    input wire logic [1:0] sel_i,
    // Result.
    output logic expired_o
);
    localparam logic [12:0] L0 = 13'(`MTIL_TO_CYC(`MTIL_TO0_DUS));
    localparam logic [12:0] L1 = 13'(`MTIL_TO_CYC(`MTIL_TO1_DUS));
    localparam logic [12:0] L2 = 13'(`MTIL_TO_CYC(`MTIL_TO2_DUS));
    localparam logic [12:0] L3 = 13'(`MTIL_TO_CYC(`MTIL_TO3_DUS));

    logic [12:0] count; // Cycles waited so far.
    logic armed; // A response is awaited.
    wire logic [12:0] limit = (sel_i == 2'd0) ? L0 : (sel_i == 2'd1) ? L1 :
                              (sel_i == 2'd2) ? L2 : L3;
    wire logic hit = armed && (count == limit);

    // Count while armed; the late response is caught once and disarms.
    always_ff @(posedge clk_i) begin
        if (rst_i || seen_i || hit) begin
            armed <= 1'b0;
            count <= 13'h0000;
        end else if (start_i) begin
            armed <= 1'b1;
            count <= 13'h0001;
        end else if (armed) begin
            count <= count + 13'h0001;
        end
    end

    // Expiry pulse, registered.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            expired_o <= 1'b0;
        end else begin
            expired_o <= hit;
        end
    end
endmodule : mtil_timeout

/* mtil_top.sv */
// Interrupt event detection, status latching and request output of a 1553 terminal.
//
// Functional notes
// RULE_01: Controller retried message raises retry interrupt.
// RULE_02: Address plus parity not odd raises interrupt.
// RULE_03: Time tag wrap to zero raises interrupt.
// RULE_04: Buffer rollover needs mask, memory mode, control flag.
// RULE_05: Overwrite off: rollover at bottom word access.
// RULE_06: Overwrite on: rollover at good message end.
// RULE_07: Controller word end interrupt needs three enables.
// RULE_08: Terminal subaddress word enables end interrupt.
// RULE_09: Frame done when message count reaches all ones.
// RULE_10: Stop-on-error abort suppresses frame done.
// RULE_11: Loopback failure raises format error.
// RULE_12: Invalid received message raises format error.
// RULE_13: Late response raises format error, selectable timeout.
// RULE_14: Terminal-to-terminal receive timeout flags format error.
// RULE_15: Bad status address or bits raises status set.
// RULE_16: Masked broadcast expects broadcast-received bit set.
// RULE_17: Mode code interrupt only with enhanced handling.
// RULE_18: Word monitor trigger pattern match raises interrupt.
// RULE_19: End of message on every message; the code gives none in word monitor mode.
// RULE_20: Request asserts on masked condition, pulse or level.
// RULE_21: Level cleared by status read or reset bit.
// RULE_22: Status latches with mask unless enhanced interrupts.
// RULE_23: Fixed bit positions for the nine interrupts.
// RULE_24: Non-enhanced only bits seven to zero work.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "mtil_params.svh"

module mtil_top (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic RST_I,
    // APB slave.
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Protocol engine events, same clock.
    input wire logic [1:0] MODE_I,
    input wire mtil_pkg::mtil_evt_t EVT_I,
    input wire mtil_pkg::mtil_qual_t QUAL_I,
    input wire logic TTAG_TICK_I,
    // Terminal address strap pins.
    input wire logic [4:0] TERMINAL_ADDRESS_INPUTS_I,
    input wire logic TERMINAL_ADDRESS_PARITY_INPUT_I,
    // Interrupt requests: IRQ_N_O active low, FRAME_DONE_IRQ_O active high.
    output logic IRQ_N_O,
    output logic FRAME_DONE_IRQ_O
);
    // Registers written by software.
    logic [15:0] mask;
    logic [15:0] cfg2;
    logic [15:0] cfg3;
    logic [15:0] cfg4;
    logic [15:0] cfg5;
    logic [15:0] trig_pat;
    // State.
    logic [15:0] status;
    logic [15:0] ttag;
    logic irq_level; // Held level request.
    // Address pin synchronisers.
    logic [5:0] adr_s1;
    logic [5:0] adr_s2;

    // Mode decode.
    wire logic is_bc = (MODE_I == 2'(mtil_pkg::MTIL_BC));
    wire logic is_rt = (MODE_I == 2'(mtil_pkg::MTIL_RT));
    wire logic is_wm = (MODE_I == 2'(mtil_pkg::MTIL_WMON));
    wire logic is_mm = (MODE_I == 2'(mtil_pkg::MTIL_MMON));
    wire logic enh = cfg3[`MTIL_C3_ENH];
    wire logic enh_irq = enh && cfg2[`MTIL_C2_ENHIRQ];
    wire logic emm = cfg2[`MTIL_C2_EMM];

    // APB decode.
    wire logic acc = PSEL_I && PENABLE_I;
    wire logic wr = acc && PWRITE_I;
    wire logic rd_stat = acc && !PWRITE_I && (PADDR_I == `MTIL_OFF_STAT);
    wire logic mapped = (PADDR_I[1:0] == 2'b00) && (PADDR_I <= `MTIL_OFF_TRIG);
    wire logic irq_rst = wr && (PADDR_I == `MTIL_OFF_CTRL) &&
                         PWDATA_I[`MTIL_CTRL_IRQRST];

    // Timeout shared by controller, monitor and terminal-to-terminal cases.
    logic timeout;
    wire logic to_start = EVT_I.rsp_start && (is_bc || is_mm || (is_rt && EVT_I.rt2rt_rx)); // RULE_13 RULE_14
    mtil_timeout u_to (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .start_i(to_start),
        .seen_i(EVT_I.rsp_seen),
        .sel_i(cfg5[10:9]),
        .expired_o(timeout)
    );

    // Address parity: six inputs must sum odd.
    wire logic apar_bad = ~^adr_s2; // RULE_02

    // Time tag wrap from all ones.
    wire logic tt_wrap = TTAG_TICK_I && (ttag == 16'hffff); // RULE_03

    // Status word check with the broadcast exception.
    wire logic bmask = QUAL_I.bc_ctrl[`MTIL_BC_BCR];
    wire logic exp_bcr = (!enh || !cfg4[`MTIL_C4_BMASK]) && bmask; // RULE_16
    wire logic [7:0] sts_bits = {QUAL_I.rx_word[9], QUAL_I.rx_word[8],
                                 QUAL_I.rx_word[4:0], QUAL_I.rx_word[10]};
    wire logic [7:0] sts_exp = {1'b0, 1'b0, exp_bcr, 5'h00};
    wire logic sts_bad = (QUAL_I.rx_word[15:11] != QUAL_I.exp_addr) ||
                         (sts_bits != sts_exp); // RULE_15

    // Event conditions at their bit positions.
    logic [15:0] cond;
    wire logic roll_ok = emm && is_rt && QUAL_I.sa_roll_en; // RULE_04
    wire logic roll_now = !cfg2[`MTIL_C2_REPLACE] && EVT_I.buf_bottom; // RULE_05
    wire logic roll_end = cfg2[`MTIL_C2_REPLACE] && EVT_I.msg_end && EVT_I.buf_bottom &&
                          (EVT_I.is_tx || !EVT_I.msg_err); // RULE_06
    always_comb begin
        cond = 16'h0000;
        cond[`MTIL_B_RETRY] = is_bc && EVT_I.retried; // RULE_01
        cond[`MTIL_B_APAR] = apar_bad; // RULE_02
        cond[`MTIL_B_TTROLL] = tt_wrap; // RULE_03
        cond[`MTIL_B_CBROLL] = roll_ok && (roll_now || roll_end); // RULE_04 RULE_05 RULE_06
        cond[`MTIL_B_CWEOM] = EVT_I.msg_end &&
            ((is_bc && cfg4[`MTIL_C4_WIDECW] && QUAL_I.bc_ctrl[4]) || // RULE_07
             (is_rt && emm && QUAL_I.sa_eom_en)); // RULE_08
        cond[`MTIL_B_EOF] = is_bc && EVT_I.msg_end && !EVT_I.stop_abort &&
                            (QUAL_I.msg_count == 16'hffff); // RULE_09 RULE_10
        cond[`MTIL_B_FMT] = EVT_I.loop_fail || // RULE_11
                            (EVT_I.msg_end && EVT_I.msg_err) || // RULE_12
                            timeout; // RULE_13 RULE_14
        cond[`MTIL_B_STSET] = (is_bc && EVT_I.sts_valid && sts_bad) || // RULE_15
            (is_rt && enh && cfg3[`MTIL_C3_EMC] && EVT_I.msg_end &&
             EVT_I.is_modecode && QUAL_I.mc_irq_en) || // RULE_17
            (is_wm && enh && EVT_I.cmd_valid && (QUAL_I.rx_word == trig_pat)); // RULE_18
        cond[`MTIL_B_EOM] = EVT_I.msg_end && !is_wm; // RULE_19
    end

    // Only bits 7..0 work outside enhanced interrupts.
    wire logic [15:0] live = enh_irq ? 16'h01ff : 16'h00ff; // RULE_23 RULE_24
    wire logic [15:0] latch = cond & live & (enh_irq ? 16'hffff : mask); // RULE_22
    wire logic [15:0] req = cond & live & mask; // RULE_20
    wire logic any_req = |req;
    wire logic level_mode = cfg2[`MTIL_C2_LEVEL];
    wire logic lvl_clr = irq_rst || (rd_stat && cfg2[`MTIL_C2_AUTOCLR]); // RULE_21

    // Read mux.
    logic [15:0] rsel;
    always_comb begin
        unique case (PADDR_I)
            `MTIL_OFF_MASK: rsel = mask;
            `MTIL_OFF_STAT: rsel = status;
            `MTIL_OFF_CFG2: rsel = cfg2;
            `MTIL_OFF_CFG3: rsel = cfg3;
            `MTIL_OFF_CFG4: rsel = cfg4;
            `MTIL_OFF_CFG5: rsel = cfg5;
            `MTIL_OFF_TTAG: rsel = ttag;
            `MTIL_OFF_TRIG: rsel = trig_pat;
            default: rsel = 16'h0000;
        endcase
    end

    // Address pins pass two flops before the parity check.
    always_ff @(posedge CLK_I) begin
        adr_s1 <= {TERMINAL_ADDRESS_INPUTS_I, TERMINAL_ADDRESS_PARITY_INPUT_I};
        adr_s2 <= adr_s1;
    end

    // Software-written registers.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            mask <= `MTIL_RST_REG;
            cfg2 <= `MTIL_RST_REG;
            cfg3 <= `MTIL_RST_REG;
            cfg4 <= `MTIL_RST_REG;
            cfg5 <= `MTIL_RST_REG;
            trig_pat <= `MTIL_RST_REG;
        end else if (wr) begin
            if (PADDR_I == `MTIL_OFF_MASK) mask <= PWDATA_I[15:0];
            if (PADDR_I == `MTIL_OFF_CFG2) cfg2 <= PWDATA_I[15:0];
            if (PADDR_I == `MTIL_OFF_CFG3) cfg3 <= PWDATA_I[15:0];
            if (PADDR_I == `MTIL_OFF_CFG4) cfg4 <= PWDATA_I[15:0];
            if (PADDR_I == `MTIL_OFF_CFG5) cfg5 <= PWDATA_I[15:0];
            if (PADDR_I == `MTIL_OFF_TRIG) trig_pat <= PWDATA_I[15:0];
        end
    end

    // Time tag counter.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ttag <= 16'h0000;
        end else if (TTAG_TICK_I) begin
            ttag <= ttag + 16'h0001;
        end
    end

    // Status is cleared by its own read; a new event in that cycle still lands.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            status <= 16'h0000;
        end else begin
            status <= (rd_stat ? 16'h0000 : status) | latch; // RULE_22
        end
    end

    // Level request; a set in the clearing cycle wins.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_level <= 1'b0;
        end else begin
            irq_level <= (any_req && level_mode) || (irq_level && !lvl_clr); // RULE_21
        end
    end

    // Request pin: pulse low for as many cycles as the request lasts, or held low level.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            IRQ_N_O <= 1'b1;
            FRAME_DONE_IRQ_O <= 1'b0;
        end else begin
            IRQ_N_O <= !((any_req && !level_mode) ||
                         (level_mode && ((any_req) || (irq_level && !lvl_clr)))); // RULE_20
            FRAME_DONE_IRQ_O <= req[`MTIL_B_EOF]; // RULE_09
        end
    end

    // APB answer: zero wait states, error on unmapped word.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PRDATA_O <= 32'h0000_0000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !mapped;
            PRDATA_O <= {16'h0000, rsel};
        end
    end

    // Assertions.
    property p_pulse_one;
        @(posedge CLK_I) disable iff (RST_I)
        (!level_mode && !any_req) |=> IRQ_N_O;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("pulse request without cause"); // RULE_20

    property p_lvl_hold;
        @(posedge CLK_I) disable iff (RST_I)
        (level_mode && any_req) |=> (!IRQ_N_O && irq_level);
    endproperty
    a_lvl_hold: assert property (p_lvl_hold) else $error("level request not raised"); // RULE_21

    property p_nomask;
        @(posedge CLK_I) disable iff (RST_I)
        (!enh_irq && cond[0] && !mask[0] && !status[0] && !rd_stat) |=> !status[0];
    endproperty
    a_nomask: assert property (p_nomask) else $error("status set without mask"); // RULE_22

    property p_enh_latch;
        @(posedge CLK_I) disable iff (RST_I)
        (enh_irq && cond[`MTIL_B_RETRY]) |=> status[`MTIL_B_RETRY];
    endproperty
    a_enh_latch: assert property (p_enh_latch) else $error("enhanced status missed"); // RULE_22

    property p_hi_bits;
        @(posedge CLK_I) disable iff (RST_I)
        (!enh_irq && !status[8] && !rd_stat) |=> !status[8];
    endproperty
    a_hi_bits: assert property (p_hi_bits) else $error("bit 8 set in base mode"); // RULE_24

    property p_abort;
        @(posedge CLK_I) disable iff (RST_I)
        EVT_I.stop_abort |=> !FRAME_DONE_IRQ_O;
    endproperty
    a_abort: assert property (p_abort) else $error("frame done after abort"); // RULE_10

    property p_parity;
        @(posedge CLK_I) disable iff (RST_I)
        (apar_bad && enh_irq) |=> status[`MTIL_B_APAR];
    endproperty
    a_parity: assert property (p_parity) else $error("parity error not latched"); // RULE_02

    sequence s_wrap;
        TTAG_TICK_I && (ttag == 16'hffff);
    endsequence
    property p_wrap;
        @(posedge CLK_I) disable iff (RST_I)
        (s_wrap and enh_irq) |=> (ttag == 16'h0000) && status[`MTIL_B_TTROLL];
    endproperty
    a_wrap: assert property (p_wrap) else $error("time tag wrap missed"); // RULE_03
endmodule : mtil_top

/* mtil_host.sv */
// Host processor model: an APB master that reads status and clears the request.
`timescale 1ns/10ps
`include "mtil_params.svh"

module mtil_host (
    // Clock.
    input wire logic clk_i,
    // APB master outputs.
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    // APB answer from the device.
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    // The bus is idle from time zero so the device never sees an unknown select.
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0000_0000;
    end

    // One transfer; the request is held until pready is seen high at a rising edge.
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= addr;
        pwdata_o <= wdata;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) begin
            @(posedge clk_i);
        end
        rdata = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released data lines show the inverse, so a stale value is never mistaken.
        pwdata_o <= ~wdata;
    endtask : xfer

    // A level request is dropped by writing one to the reset bit of the control register.
    task automatic clear_irq();
        logic [31:0] d;
        logic e;
        xfer(1'b1, `MTIL_OFF_CTRL, 32'h0000_0004, d, e);
    endtask : clear_irq
endmodule : mtil_host

/* mil1553_terminal_interrupt_logic_test.sv */
// Self-checking testbench of the terminal interrupt logic.
`timescale 1ns/10ps
`include "mtil_params.svh"

module mil1553_terminal_interrupt_logic_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, irq_n, frame_done, tpar, err, i1, i2, f1;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] mode = 2'h0;
    logic [4:0] taddr = 5'h01;
    logic tick = 1'b0;
    mtil_pkg::mtil_evt_t evt = '0;
    mtil_pkg::mtil_qual_t qual = '0;
    mtil_pkg::mtil_evt_t e;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    initial tpar = 1'b0;
    // A 50 MHz clock.
    always #10 clk = ~clk;

    mtil_top u_dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .MODE_I(mode), .EVT_I(evt), .QUAL_I(qual),
        .TTAG_TICK_I(tick), .TERMINAL_ADDRESS_INPUTS_I(taddr),
        .TERMINAL_ADDRESS_PARITY_INPUT_I(tpar), .IRQ_N_O(irq_n), .FRAME_DONE_IRQ_O(frame_done));

    mtil_host u_host (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr));

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // A hang is cut short well after the longest scenario.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            bad_count++;
            summarize();
        end
    end

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        u_host.xfer(1'b0, a, 32'h0, rd, err);
        chk(what, exp, rd);
    endtask : rchk

    // One event cycle; the request is sampled just after the edge the design takes it on and one edge later.
    task automatic pulse(input mtil_pkg::mtil_evt_t ev, input logic [15:0] cnt,
                         input logic [15:0] ctl);
        @(posedge clk);
        evt <= ev;
        qual.msg_count <= cnt;
        qual.bc_ctrl <= ctl;
        @(posedge clk);
        evt <= '0;
        #1;
        i1 = irq_n;
        f1 = frame_done;
        @(posedge clk);
        #1;
        i2 = irq_n;
    endtask : pulse

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk("irq after reset", 32'h1, {31'h0, irq_n});
        rchk("mask reset", `MTIL_OFF_MASK, 32'h0);
        rchk("cfg2 reset", `MTIL_OFF_CFG2, 32'h0);
        u_host.xfer(1'b0, 12'h040, 32'h0, rd, err);
        chk("unmapped error", 32'h1, {31'h0, err});
        e = '0;
        e.msg_end = 1'b1;
        // With the mask clear nothing latches and no request is made.
        pulse(e, 16'h0000, 16'h0000);
        chk("unmasked irq", 32'h1, {31'h0, i1});
        rchk("unmasked status", `MTIL_OFF_STAT, 32'h0);
        wr(`MTIL_OFF_MASK, 32'h0000_01ff);
        pulse(e, 16'h0000, 16'h0000);
        chk("pulse low", 32'h0, {31'h0, i1});
        chk("pulse ends", 32'h1, {31'h0, i2});
        rchk("eom status", `MTIL_OFF_STAT, 32'h1);
        rchk("status cleared", `MTIL_OFF_STAT, 32'h0);
        // Frame done only when the count reaches all ones.
        pulse(e, 16'hffff, 16'h0000);
        chk("frame done", 32'h1, {31'h0, f1});
        rchk("frame status", `MTIL_OFF_STAT, 32'h9);
        // An aborted frame gives no frame done even at all ones.
        e.stop_abort = 1'b1;
        pulse(e, 16'hffff, 16'h0000);
        chk("abort frame done", 32'h0, {31'h0, f1});
        rchk("abort status", `MTIL_OFF_STAT, 32'h1);
        e.stop_abort = 1'b0;
        pulse(e, 16'hfffe, 16'h0000);
        chk("no frame done", 32'h0, {31'h0, f1});
        rchk("short frame", `MTIL_OFF_STAT, 32'h1);
        // Control word end needs the wide word option as well.
        pulse(e, 16'h0000, 16'h0010);
        rchk("cw eom off", `MTIL_OFF_STAT, 32'h1);
        wr(`MTIL_OFF_CFG4, 32'h0000_1000);
        pulse(e, 16'h0000, 16'h0010);
        rchk("cw eom on", `MTIL_OFF_STAT, 32'h11);
        e = '0;
        e.retried = 1'b1;
        pulse(e, 16'h0000, 16'h0000);
        rchk("retry plain", `MTIL_OFF_STAT, 32'h0);
        e = '0;
        e.loop_fail = 1'b1;
        pulse(e, 16'h0000, 16'h0000);
        rchk("loop fail", `MTIL_OFF_STAT, 32'h4);
        // Even parity on the strap pins is flagged while it lasts.
        @(posedge clk);
        taddr <= 5'h00;
        repeat (4) @(posedge clk);
        rchk("parity bad", `MTIL_OFF_STAT, 32'h80);
        tpar <= 1'b1;
        repeat (4) @(posedge clk);
        u_host.xfer(1'b0, `MTIL_OFF_STAT, 32'h0, rd, err);
        rchk("parity good", `MTIL_OFF_STAT, 32'h0);
        // Enhanced interrupts latch status with the mask clear, and bit 8 works.
        wr(`MTIL_OFF_CFG3, 32'h0000_8000);
        wr(`MTIL_OFF_CFG2, 32'h0000_8000);
        wr(`MTIL_OFF_MASK, 32'h0);
        pulse(e, 16'h0000, 16'h0000);
        e = '0;
        e.retried = 1'b1;
        pulse(e, 16'h0000, 16'h0000);
        chk("enh irq", 32'h1, {31'h0, i1});
        rchk("enh status", `MTIL_OFF_STAT, 32'h104);
        // Level request stays until the host clears it.
        wr(`MTIL_OFF_MASK, 32'h0000_01ff);
        wr(`MTIL_OFF_CFG2, 32'h0000_0008);
        e = '0;
        e.msg_end = 1'b1;
        pulse(e, 16'h0000, 16'h0000);
        repeat (3) @(posedge clk);
        chk("level held", 32'h0, {31'h0, irq_n});
        u_host.clear_irq();
        repeat (2) @(posedge clk);
        chk("level cleared", 32'h1, {31'h0, irq_n});
        wr(`MTIL_OFF_CFG2, 32'h0000_0018);
        pulse(e, 16'h0000, 16'h0000);
        chk("auto level", 32'h0, {31'h0, i2});
        rchk("auto status", `MTIL_OFF_STAT, 32'h1);
        repeat (2) @(posedge clk);
        chk("auto cleared", 32'h1, {31'h0, irq_n});
        // Shortest response timeout: 925 cycles, not earlier.
        wr(`MTIL_OFF_CFG2, 32'h0);
        e = '0;
        e.rsp_start = 1'b1;
        pulse(e, 16'h0000, 16'h0000);
        repeat (900) @(posedge clk);
        rchk("timeout early", `MTIL_OFF_STAT, 32'h0);
        repeat (40) @(posedge clk);
        rchk("timeout late", `MTIL_OFF_STAT, 32'h4);
        // Terminal mode: rollover at the bottom word, or at a good message end.
        mode <= 2'h1;
        qual.sa_roll_en <= 1'b1;
        wr(`MTIL_OFF_CFG2, 32'h0000_0002);
        e = '0;
        e.buf_bottom = 1'b1;
        pulse(e, 16'h0000, 16'h0000);
        rchk("roll now", `MTIL_OFF_STAT, 32'h20);
        wr(`MTIL_OFF_CFG2, 32'h0000_0802);
        e.msg_end = 1'b1;
        e.msg_err = 1'b1;
        pulse(e, 16'h0000, 16'h0000);
        rchk("roll bad rx", `MTIL_OFF_STAT, 32'h5);
        e.msg_err = 1'b0;
        pulse(e, 16'h0000, 16'h0000);
        rchk("roll good rx", `MTIL_OFF_STAT, 32'h21);
        qual.sa_eom_en <= 1'b1;
        e.buf_bottom = 1'b0;
        pulse(e, 16'h0000, 16'h0000);
        rchk("rt cw eom", `MTIL_OFF_STAT, 32'h11);
        // Word monitor: a trigger match raises bit 1, a message end nothing.
        mode <= 2'h2;
        qual.rx_word <= 16'h1234;
        wr(`MTIL_OFF_CFG3, 32'h0000_8000);
        wr(`MTIL_OFF_TRIG, 32'h0000_1234);
        pulse(e, 16'h0000, 16'h0000);
        rchk("wm no eom", `MTIL_OFF_STAT, 32'h0);
        e = '0;
        e.cmd_valid = 1'b1;
        pulse(e, 16'h0000, 16'h0000);
        rchk("trigger", `MTIL_OFF_STAT, 32'h2);
        // Controller status word: wrong address, then the broadcast exception.
        mode <= 2'h0;
        qual.rx_word <= 16'h0800;
        e = '0;
        e.sts_valid = 1'b1;
        pulse(e, 16'h0000, 16'h0000);
        rchk("bad sts addr", `MTIL_OFF_STAT, 32'h2);
        qual.rx_word <= 16'h0010;
        pulse(e, 16'h0000, 16'h0010);
        rchk("bcast expected", `MTIL_OFF_STAT, 32'h0);
        // A full count of the time tag wraps it to zero once.
        tick <= 1'b1;
        repeat (65536) @(posedge clk);
        tick <= 1'b0;
        rchk("ttag wrap", `MTIL_OFF_STAT, 32'h40);
        rchk("ttag zero", `MTIL_OFF_TTAG, 32'h0);
        summarize();
    end
endmodule : mil1553_terminal_interrupt_logic_test
